// >>> verilog/dcm_params.svh
// register offsets, field positions, reset values and timing counts for the clock mode block
`ifndef DCM_PARAMS_SVH
`define DCM_PARAMS_SVH

`define DCM_OFF_OSC_CTRL   12'h000
`define DCM_OFF_CFG        12'h004
`define DCM_OFF_STATUS     12'h008
`define DCM_OFF_WAKE       12'h00c

`define DCM_BIT_HSEL       0
`define DCM_BIT_FSTOP      1
`define DCM_BIT_MODE_LO    2
`define DCM_BIT_MODE_HI    3
`define DCM_BIT_T0SLOW     4

`define DCM_BIT_CFG_DIV4   0
`define DCM_BIT_CFG_FSRC   1
`define DCM_BIT_CFG_SSRC   2
`define DCM_BIT_CFG_START  3
`define DCM_BIT_CFG_T0SRC  4
`define DCM_BIT_CFG_CKOUT  5
`define DCM_BIT_CFG_FRQ_LO 8
`define DCM_BIT_CFG_FRQ_HI 10

`define DCM_OSC_CTRL_RST   8'h01
`define DCM_CFG_RST        16'h0000

`define DCM_SYNC_STAGES    2

`endif

// >>> verilog/dcm_pkg.sv
// types shared by the clock mode block
package dcm_pkg;

  typedef enum logic [1:0] {
    DCM_MODE_NORMAL  = 2'b00,
    DCM_MODE_SLOW    = 2'b01,
    DCM_MODE_STANDBY = 2'b10,
    DCM_MODE_HALT    = 2'b11
  } dcm_mode_t;

  // encoding of the two-bit operating-mode field
  typedef enum logic [1:0] {
    DCM_OPF_RUN     = 2'b00,
    DCM_OPF_HALT    = 2'b01,
    DCM_OPF_STANDBY = 2'b10,
    DCM_OPF_RSVD    = 2'b11
  } dcm_opf_t;

  typedef enum logic [2:0] {
    DCM_FRQ_1M  = 3'b000,
    DCM_FRQ_2M  = 3'b001,
    DCM_FRQ_4M  = 3'b010,
    DCM_FRQ_8M  = 3'b011,
    DCM_FRQ_16M = 3'b100,
    DCM_FRQ_20M = 3'b101
  } dcm_frq_t;

endpackage

// >>> verilog/dcm_clock_mode.sv
// dual clock source selection, instruction clock divider and operating mode sequencer
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`include "dcm_params.svh"

// Summary of operation
// - high_osc_select picks fast or slow system clock
// - instruction clock is system clock /2 or /4
// - internal fast rc trimmed to 1..20 MHz
// - internal rc frees pads; pad b may output clock
// - crystal modes claim both pads as xin/xout
// - slow source is 32768 Hz rc or crystal
// - only three fast/slow source pairings allowed
// - after reset start normal or slow per strap
// - normal runs fast clock, slow oscillator stays on
// - select 0 enters slow, fast oscillator kept
// - fast_osc_stop at bit 1 stops fast oscillator only while select is 0 (slow clock)
// - op_mode_field bits 3:2 enter standby or halt
// - select 1 in slow returns to normal
// - slow clock drives timer0 when both bits set
// - standby keeps only timers and watchdog alive
// - halt sleeps until external or watchdog wake
// - field value 10 enters standby
// - field value 01 enters halt
// - halt disables both oscillators
// - wake resumes normal or slow per select bit
module dcm_clock_mode #(
  parameter int FRQ_W = 3
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fast_osc_clock,
  input  wire logic        slow_osc_clock,
  input  wire logic        ext_wake,
  input  wire logic        wdt_wake,
  input  wire logic        timer_wake,
  input  wire logic        pad_a_gpio_out,
  input  wire logic        pad_a_gpio_oe,
  input  wire logic        pad_b_gpio_out,
  input  wire logic        pad_b_gpio_oe,
  output logic             crystal_pad_a_out,
  output logic             crystal_pad_a_oe,
  output logic             crystal_pad_b_out,
  output logic             crystal_pad_b_oe,
  output logic             xtal_fast_en,
  output logic             xtal_slow_en,
  output logic             fast_osc_en,
  output logic             slow_osc_en,
  output logic [FRQ_W-1:0] fast_rc_trim,
  output logic             system_osc_clock,
  output logic             instruction_clock,
  output logic             timer0_slow_clk,
  output logic             cpu_run,
  output logic             timers_run,
  output logic             periph_run,
  output logic [1:0]       cur_mode
);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic        high_osc_select_r;
  logic        fast_osc_stop_r;
  logic [1:0]  op_mode_field_r;
  logic        slow_clk_to_timer0_r;
  logic [15:0] cfg_r;
  logic        cfg_lock_r;
  logic [2:0]  wake_cause_r;
  dcm_pkg::dcm_mode_t mode_r;
  dcm_pkg::dcm_mode_t mode_nxt;

  // ---------------------------------------------------------------
  // mode decoding shared by the sequencer and the run controls
  // ---------------------------------------------------------------
  function automatic logic dcm_is_run(input dcm_pkg::dcm_mode_t m);
    return (m == dcm_pkg::DCM_MODE_NORMAL) || (m == dcm_pkg::DCM_MODE_SLOW);
  endfunction

  function automatic logic dcm_is_sleep(input dcm_pkg::dcm_mode_t m);
    return (m == dcm_pkg::DCM_MODE_STANDBY) || (m == dcm_pkg::DCM_MODE_HALT);
  endfunction

  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire hit_ctrl = (paddr == `DCM_OFF_OSC_CTRL);
  wire hit_cfg  = (paddr == `DCM_OFF_CFG);
  wire hit_stat = (paddr == `DCM_OFF_STATUS);
  wire hit_wake = (paddr == `DCM_OFF_WAKE);
  wire mapped   = hit_ctrl | hit_cfg | hit_stat | hit_wake;
  wire wr_ctrl  = wr & hit_ctrl;
  wire wr_cfg   = wr & hit_cfg & ~cfg_lock_r;

  // configuration word fields
  wire cfg_div4   = cfg_r[`DCM_BIT_CFG_DIV4];
  wire cfg_fxtal  = cfg_r[`DCM_BIT_CFG_FSRC];
  wire cfg_sxtal  = cfg_r[`DCM_BIT_CFG_SSRC];
  wire cfg_start  = cfg_r[`DCM_BIT_CFG_START];
  wire cfg_t0src  = cfg_r[`DCM_BIT_CFG_T0SRC];
  wire cfg_ckout  = cfg_r[`DCM_BIT_CFG_CKOUT];
  wire [2:0] cfg_frq = cfg_r[`DCM_BIT_CFG_FRQ_HI:`DCM_BIT_CFG_FRQ_LO];
  // both crystals at once is no legal pairing; the slow crystal then yields
  wire sxtal_eff  = cfg_sxtal & ~cfg_fxtal;
  wire any_xtal   = cfg_fxtal | sxtal_eff;

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  wire [31:0] ctrl_rd = {27'h0, slow_clk_to_timer0_r, op_mode_field_r,
                         fast_osc_stop_r, high_osc_select_r};
  wire [31:0] stat_rd = {29'h0, cfg_lock_r, mode_r};
  wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd :
                        hit_cfg  ? {16'h0, cfg_r} :
                        hit_stat ? stat_rd :
                        hit_wake ? {29'h0, wake_cause_r} : 32'h0;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0;
    end else if (acc && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // mode sequencer
  // ---------------------------------------------------------------
  wire [1:0] wr_opf   = pwdata[`DCM_BIT_MODE_HI:`DCM_BIT_MODE_LO];
  wire       wr_hsel  = pwdata[`DCM_BIT_HSEL];
  // control writes are only honoured while running; a sleeping core
  // cannot issue them, so a stray bus access must not change the mode
  wire       running  = dcm_is_run(mode_r);
  wire       resume   = high_osc_select_r ? 1'b1 : 1'b0;
  wire       sb_wake  = timer_wake | wdt_wake | ext_wake;
  wire       hlt_wake = wdt_wake | ext_wake;
  wire       sleeping = dcm_is_sleep(mode_r);
  // timer wake is ignored in halt, since the timers are stopped there
  wire       wake_now = sleeping &&
                        ((mode_r == dcm_pkg::DCM_MODE_HALT) ? hlt_wake : sb_wake);

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      dcm_pkg::DCM_MODE_NORMAL, dcm_pkg::DCM_MODE_SLOW: begin
        if (wr_ctrl && wr_opf == dcm_pkg::DCM_OPF_STANDBY) begin
          mode_nxt = dcm_pkg::DCM_MODE_STANDBY;
        end else if (wr_ctrl && wr_opf == dcm_pkg::DCM_OPF_HALT) begin
          mode_nxt = dcm_pkg::DCM_MODE_HALT;
        end else if (wr_ctrl) begin
          mode_nxt = wr_hsel ? dcm_pkg::DCM_MODE_NORMAL
                             : dcm_pkg::DCM_MODE_SLOW;
        end
      end
      dcm_pkg::DCM_MODE_STANDBY, dcm_pkg::DCM_MODE_HALT: begin
        if (wake_now) begin
          mode_nxt = resume ? dcm_pkg::DCM_MODE_NORMAL
                            : dcm_pkg::DCM_MODE_SLOW;
        end
      end
      default: mode_nxt = dcm_pkg::DCM_MODE_NORMAL;
    endcase
  end

  // start mode is decided by the strap in cfg, taken one edge after release
  logic boot_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
    end
  end

  // the strap is read after release, not in reset, so the reset branch
  // stays constant; the first bus access may only follow that edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= dcm_pkg::DCM_MODE_NORMAL;
      high_osc_select_r <= 1'b1;
    end else if (boot_r) begin
      mode_r <= cfg_start ? dcm_pkg::DCM_MODE_NORMAL : dcm_pkg::DCM_MODE_SLOW;
      high_osc_select_r <= cfg_start;
    end else begin
      mode_r <= mode_nxt;
      if (wr_ctrl && running) begin
        high_osc_select_r <= wr_hsel;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fast_osc_stop_r      <= 1'b0;
      op_mode_field_r      <= 2'b00;
      slow_clk_to_timer0_r <= 1'b0;
    end else if (wr_ctrl && running) begin
      fast_osc_stop_r      <= pwdata[`DCM_BIT_FSTOP];
      op_mode_field_r      <= wr_opf;
      slow_clk_to_timer0_r <= pwdata[`DCM_BIT_T0SLOW];
    end else if (wake_now) begin
      op_mode_field_r <= dcm_pkg::DCM_OPF_RUN;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= `DCM_CFG_RST;
    end else if (wr_cfg) begin
      cfg_r <= pwdata[15:0];
    end
  end

  // configuration locks on the first control write, so the source
  // pairing cannot be changed under a running clock
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_lock_r <= 1'b0;
    end else if (wr_ctrl) begin
      cfg_lock_r <= 1'b1;
    end
  end

  // last wake cause is kept until the next wake; a read does not clear it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_cause_r <= 3'h0;
    end else if (wake_now) begin
      wake_cause_r <= {timer_wake, wdt_wake, ext_wake};
    end
  end

  // ---------------------------------------------------------------
  // oscillator enables and pads
  // ---------------------------------------------------------------
  wire in_halt = (mode_r == dcm_pkg::DCM_MODE_HALT);
  // stop only honoured off the fast clock, so a combined write cannot hang
  wire fast_stop_ok = fast_osc_stop_r && !high_osc_select_r;

  assign fast_osc_en  = ~in_halt & ~fast_stop_ok;
  assign slow_osc_en  = ~in_halt;
  assign xtal_fast_en = cfg_fxtal & fast_osc_en;
  assign xtal_slow_en = sxtal_eff & slow_osc_en;
  assign fast_rc_trim = cfg_fxtal ? '0 : cfg_frq[FRQ_W-1:0];

  // crystal modes take both pads away from gpio; xin is input only
  assign crystal_pad_a_out = any_xtal ? 1'b0 : pad_a_gpio_out;
  assign crystal_pad_a_oe  = any_xtal ? 1'b0 : pad_a_gpio_oe;
  assign crystal_pad_b_out = any_xtal ? 1'b0 :
                             cfg_ckout ? instruction_clock : pad_b_gpio_out;
  assign crystal_pad_b_oe  = any_xtal ? 1'b0 : (cfg_ckout | pad_b_gpio_oe);

  // ---------------------------------------------------------------
  // glitch free source switch
  // ---------------------------------------------------------------
  // each leg is released only after the other leg has closed, both
  // handshakes synchronised into the leg's own clock on the falling edge
  // limitation: if the target oscillator is stopped the switch never
  // completes and the system clock stays low; firmware must keep the
  // target running before it changes the select bit
  // trade-off: a switch costs a few periods of each clock in latency
  logic [1:0] fsync_r;
  logic [1:0] ssync_r;
  logic       fgate_r;
  logic       sgate_r;
  wire        want_fast = high_osc_select_r;

  always_ff @(negedge fast_osc_clock or negedge arst_n) begin
    if (!arst_n) begin
      fsync_r <= 2'b00;
      fgate_r <= 1'b0;
    end else begin
      fsync_r <= {fsync_r[0], want_fast & ~sgate_r};
      fgate_r <= fsync_r[1];
    end
  end

  always_ff @(negedge slow_osc_clock or negedge arst_n) begin
    if (!arst_n) begin
      ssync_r <= 2'b00;
      sgate_r <= 1'b0;
    end else begin
      ssync_r <= {ssync_r[0], ~want_fast & ~fgate_r};
      sgate_r <= ssync_r[1];
    end
  end

  assign system_osc_clock = (fast_osc_clock & fgate_r) | (slow_osc_clock & sgate_r);

  // instruction clock divider on the system clock; it stalls with the
  // gated clock during a source switch, which keeps its phase clean
  logic [1:0] div_r;

  always_ff @(posedge system_osc_clock or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= 2'b00;
    end else begin
      div_r <= div_r + 2'b01;
    end
  end

  logic ck_r;

  always_ff @(posedge system_osc_clock or negedge arst_n) begin
    if (!arst_n) begin
      ck_r <= 1'b0;
    end else begin
      ck_r <= cfg_div4 ? div_r[1] : ~ck_r;
    end
  end

  assign instruction_clock = ck_r;
  assign timer0_slow_clk   = slow_clk_to_timer0_r & cfg_t0src & slow_osc_clock;

  // ---------------------------------------------------------------
  // domain run controls
  // ---------------------------------------------------------------
  assign cpu_run    = running;
  assign periph_run = running;
  assign timers_run = ~in_halt;
  assign cur_mode   = mode_r;

endmodule

// >>> sim/dcm_clock_mode_props.sv
// assertion checker for the clock mode block
`timescale 1ns/1ps
module dcm_clock_mode_props (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        ext_wake,
  input wire logic        wdt_wake,
  input wire logic        timer_wake,
  input wire logic        crystal_pad_a_oe,
  input wire logic        xtal_fast_en,
  input wire logic        xtal_slow_en,
  input wire logic        fast_osc_en,
  input wire logic        slow_osc_en,
  input wire logic        cpu_run,
  input wire logic        timers_run,
  input wire logic [1:0]  cur_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------
  // control register write
  // ----------------------------------------
  sequence s_osc_wr;
    psel && penable && pwrite && paddr == 12'h000;
  endsequence
  sequence s_running;
    cur_mode == 2'b00 || cur_mode == 2'b01;
  endsequence

  a_halt_osc_off: assert property (
    cur_mode == 2'b11 |-> !fast_osc_en && !slow_osc_en && !timers_run && !cpu_run)
    else $error("oscillator or timers alive in halt");
  a_normal_osc_on: assert property (
    cur_mode == 2'b00 |-> fast_osc_en && slow_osc_en)
    else $error("oscillator off in normal mode");
  a_standby_run: assert property (
    cur_mode == 2'b10 |-> timers_run && !cpu_run)
    else $error("wrong run enables in standby");
  // wake lines are not synchronised and act on the next edge, so a quiet span of 4 cycles exceeds what is needed
  a_halt_sleep: assert property (
    (cur_mode == 2'b11 && !ext_wake && !wdt_wake)[*4] |=> cur_mode == 2'b11)
    else $error("left halt without a wake event");
  a_enter_slow: assert property (
    cur_mode == 2'b00 ##0 s_osc_wr ##0 pwdata[3:0] == 4'h0 |-> ##[1:3] cur_mode == 2'b01)
    else $error("select low did not enter slow");
  a_enter_normal: assert property (
    cur_mode == 2'b01 ##0 s_osc_wr ##0 pwdata[3:0] == 4'h1 |-> ##[1:3] cur_mode == 2'b00)
    else $error("select high did not enter normal");
  a_enter_halt: assert property (
    s_running ##0 s_osc_wr ##0 pwdata[3:2] == 2'b01 |-> ##[1:3] cur_mode == 2'b11)
    else $error("field 01 did not enter halt");
  a_enter_standby: assert property (
    s_running ##0 s_osc_wr ##0 pwdata[3:2] == 2'b10 |-> ##[1:3] cur_mode == 2'b10)
    else $error("field 10 did not enter standby");
  a_fast_stop: assert property (
    cur_mode == 2'b01 ##0 s_osc_wr ##0 pwdata[1:0] == 2'b10 |-> ##[1:3] !fast_osc_en)
    else $error("fast oscillator not stopped");
  a_xtal_pads: assert property (
    xtal_fast_en || xtal_slow_en |-> !crystal_pad_a_oe)
    else $error("crystal pad driven as gpio");
endmodule

bind dcm_clock_mode dcm_clock_mode_props u_props (
  .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .ext_wake(ext_wake), .wdt_wake(wdt_wake),
  .timer_wake(timer_wake), .crystal_pad_a_oe(crystal_pad_a_oe),
  .xtal_fast_en(xtal_fast_en), .xtal_slow_en(xtal_slow_en), .fast_osc_en(fast_osc_en),
  .slow_osc_en(slow_osc_en), .cpu_run(cpu_run), .timers_run(timers_run),
  .cur_mode(cur_mode));

// >>> sim/dcm_clock_mode_tb.sv
// self-checking bench for the clock mode block
`timescale 1ns/1ps
module dcm_clock_mode_tb;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        fast_osc_clock = 1'b0;
  logic        slow_osc_clock = 1'b0;
  logic [2:0]  wake = 3'h0;
  logic [1:0]  pad_a = 2'h0;
  logic [31:0] prdata;
  logic [2:0]  fast_rc_trim;
  logic [1:0]  cur_mode;
  logic        pready, pslverr, pa_out, pa_oe, pb_out, pb_oe, xf_en, xs_en, f_en, s_en;
  logic        sys_osc, inst_clk, t0_clk, cpu_run, timers_run, periph_run;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          n_osc = 0;
  int          n_inst = 0;

  dcm_clock_mode dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_osc_clock(fast_osc_clock), .slow_osc_clock(slow_osc_clock), .ext_wake(wake[0]),
    .wdt_wake(wake[1]), .timer_wake(wake[2]), .pad_a_gpio_out(pad_a[0]),
    .pad_a_gpio_oe(pad_a[1]), .pad_b_gpio_out(1'b0), .pad_b_gpio_oe(1'b0),
    .crystal_pad_a_out(pa_out), .crystal_pad_a_oe(pa_oe), .crystal_pad_b_out(pb_out),
    .crystal_pad_b_oe(pb_oe), .xtal_fast_en(xf_en), .xtal_slow_en(xs_en),
    .fast_osc_en(f_en), .slow_osc_en(s_en), .fast_rc_trim(fast_rc_trim),
    .system_osc_clock(sys_osc), .instruction_clock(inst_clk), .timer0_slow_clk(t0_clk),
    .cpu_run(cpu_run), .timers_run(timers_run), .periph_run(periph_run),
    .cur_mode(cur_mode));

  // ----------------------------------------
  // clocks and counters
  // ----------------------------------------
  // oscillator edges fall on whole ns, never on a sys_clk rising edge
  initial forever #12.5 sys_clk = ~sys_clk;
  initial forever #4 fast_osc_clock = ~fast_osc_clock;
  initial forever #40 slow_osc_clock = ~slow_osc_clock;
  always @(posedge sys_osc) n_osc++;
  always @(posedge inst_clk) n_inst++;

  task automatic end_sim;
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // bus and wait helpers
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge sys_clk);
    end
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    q = prdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic wait_mode(input logic [1:0] m);
    int n;
    n = 0;
    while (cur_mode !== m && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    chk(cur_mode, m);
  endtask

  task automatic t_div(input int d);
    n_osc = 0;
    n_inst = 0;
    repeat (400) @(posedge sys_clk);
    chk(n_osc >= d * n_inst - d && n_osc <= d * n_inst + d, 1'b1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_start_cfg;
    logic [31:0] q;
    logic        e;
    wait_mode(2'b01);
    wr(12'h004, 32'h0000_0430);
    pad_a <= 2'b11;
    repeat (20) @(posedge sys_clk);
    chk(fast_rc_trim, 3'h4);
    chk({pa_oe, pa_out, pb_oe}, 3'b111);
    chk(pb_out, inst_clk);
    chk(pready, 1'b1);
    chk(sys_osc, slow_osc_clock);
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk(q, 32'h0);
    chk(e, 1'b1);
    apb(1'b0, 12'h004, 32'h0, q, e);
    chk(q, 32'h0000_0430);
    apb(1'b0, 12'h008, 32'h0, q, e);
    chk({e, q[2:0]}, 4'h1);
  endtask

  task automatic t_modes;
    wr(12'h000, 32'h0000_0011);
    wait_mode(2'b00);
    repeat (20) @(posedge sys_clk);
    chk({sys_osc, f_en, s_en}, {fast_osc_clock, 2'b11});
    chk(t0_clk, slow_osc_clock);
    t_div(2);
    wr(12'h000, 32'h0);
    wait_mode(2'b01);
    chk(f_en, 1'b1);
    wr(12'h000, 32'h2);
    chk(f_en, 1'b0);
    wr(12'h000, 32'h8);
    wait_mode(2'b10);
    chk({cpu_run, timers_run, periph_run}, 3'b010);
    wake <= 3'b100;
    wait_mode(2'b01);
    wake <= 3'b000;
    wr(12'h000, 32'h1);
    wr(12'h000, 32'h5);
    wait_mode(2'b11);
    chk({f_en, s_en, timers_run, cpu_run}, 4'h0);
    wake <= 3'b100;
    repeat (6) @(posedge sys_clk);
    chk(cur_mode, 2'b11);
    wake <= 3'b001;
    wait_mode(2'b00);
    wake <= 3'b000;
  endtask

  task automatic t_crystal;
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    wr(12'h004, 32'h4);
    chk({xs_en, xf_en, pa_oe}, 3'b100);
    wr(12'h004, 32'h7);
    chk({xf_en, xs_en}, 2'b10);
    t_div(4);
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    t_start_cfg();
    t_modes();
    t_crystal();
    end_sim();
  end

  initial begin
    #500000;
    n_errors++;
    end_sim();
  end
endmodule
